// file: pmon_pkg.sv
// Purpose: Constants for the power-monitor sampling control block
// Assumes: Command codes are the byte-wide PMBus command codes of the device
// Notes: Shared by the design and by the verification side
package pmon_pkg;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8C;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8D;
  localparam logic [7:0] CMD_READ_PIN = 8'h97;
  localparam logic [7:0] CMD_PEAK_CURRENT_HOLD = 8'hD0;
  localparam logic [7:0] CMD_PEAK_INPUT_VOLTAGE_HOLD = 8'hD1;
  localparam logic [7:0] CMD_PEAK_OUTPUT_VOLTAGE_HOLD = 8'hD2;
  localparam logic [7:0] CMD_MONITOR_RUN_CONTROL = 8'hD3;
  localparam logic [7:0] CMD_MONITOR_SAMPLING_CONFIG = 8'hD4;

  // ------------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------------
  localparam logic RUN_RESET = 1'b1;
  localparam logic [15:0] CFG_RESET = 16'h0714;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hFF1E;
  localparam logic [15:0] PEAK_CLEAR_VALUE = 16'h0000;
  localparam int RUN_BIT = 0;
  localparam int CFG_TEMP_FILTER_BIT = 15;
  localparam int CFG_SIMUL_BIT = 14;
  localparam int CFG_POWER_AVERAGE_LSB = 11;
  localparam int CFG_VOLT_CURRENT_AVERAGE_LSB = 8;
  localparam int CFG_MODE_BIT = 4;
  localparam int CFG_TEMP_EN_BIT = 3;
  localparam int CFG_IN_VOLT_EN_BIT = 2;
  localparam int CFG_VOUT_EN_BIT = 1;

  // ------------------------------------------------------------------
  // Channels and widths
  // ------------------------------------------------------------------
  localparam logic [1:0] CH_IOUT = 2'h0;
  localparam logic [1:0] CH_VIN = 2'h1;
  localparam logic [1:0] CH_VOUT = 2'h2;
  localparam logic [1:0] CH_TEMP = 2'h3;
  localparam int MEAS_W = 12;
  localparam int ACC_W = 19;
  localparam int PACC_W = 31;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LAUNCH = 3'b010,
    S_WAIT = 3'b100
  } samp_state_e;

endpackage : pmon_pkg

// file: pmon_sampling_ctrl.sv
// Purpose: Peak hold, run control and sampling configuration of a power monitor
// Assumes: All inputs synchronous to MCLK; ADC conversion is outside the block
// Notes: Register access is by command code, as the PMBus protocol layer delivers it
//
// Function
// - Peak current register keeps largest averaged current, 12 bits low.
// - Peak input-voltage register keeps largest averaged input voltage, 12 bits.
// - Peak output-voltage register keeps largest averaged output voltage, 12 bits.
// - Writing zero to a peak register restarts its tracking.
// - Peak registers read upper four bits as zero and reset to zero.
// - Run bit 0 of control stops or runs sampling; resets to one.
// - Config bit 4 picks single-shot or continuous; single-shot clears run after cycle.
// - Trigger rising edge or slave-select falling edge sets the run bit.
// - Trigger edges during sampling are ignored.
// - Config bit 15 enables the temperature filter; resets disabled.
// - Config bit 14 enables simultaneous sampling; resets disabled.
// - Bits 13..11 pick power averaging of 1 to 128 samples; reset 000.
// - Bits 10..8 pick voltage and current averaging; reset 128 samples.
// - Bits 3, 2, 1 add temperature, input and output voltage to rotation.
// - Control bits 7..1 read zero; config resets to 0x0714.
// - Each channel is reported averaged, 12 bits with upper four zero.
`timescale 1ns/1ps
`default_nettype none

module pmon_sampling_ctrl
  import pmon_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] CMD_CODE,
  input wire logic WR_STB,
  input wire logic [15:0] WR_DATA,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  input wire logic CONVERSION_TRIGGER_INPUT,
  input wire logic SPI_SS_N,
  output logic ADC_START,
  output logic [1:0] ADC_CHAN,
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  output logic ADC_SIMULTANEOUS,
  output logic TEMP_FILTER_ENABLE,
  output logic SAMPLING
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [2:0] next_chan(input logic [1:0] cur, input logic [3:0] en);
    logic [2:0] r;
    logic [2:0] k;
    r = {1'b1, CH_IOUT};
    for (int i = 3; i >= 1; i--)
    begin
      k = {1'b0, cur} + 3'(i);
      if (k <= 3'h3 && en[k[1:0]])
        r = {1'b0, k[1:0]};
    end
    return r;
  endfunction : next_chan

  function automatic logic [7:0] last_count(input logic [2:0] sel);
    return (8'h01 << sel) - 8'h01;
  endfunction : last_count

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  samp_state_e state_q, state_d;
  logic run_q, run_d;
  logic [15:0] cfg_q, cfg_d;
  logic [11:0] peak_q [3];
  logic [11:0] peak_d [3];
  logic [11:0] meas_q [4];
  logic [11:0] meas_d [4];
  logic [ACC_W-1:0] acc_q [4];
  logic [ACC_W-1:0] acc_d [4];
  logic [PACC_W-1:0] pacc_q, pacc_d;
  logic [15:0] pin_q, pin_d;
  logic [11:0] vin_smp_q, vin_smp_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] pcnt_q, pcnt_d;
  logic [1:0] ch_q, ch_d;
  logic trig_prev_q, trig_prev_d;
  logic ss_prev_q, ss_prev_d;
  logic [15:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic start_q, start_d;

  logic [3:0] chan_en;
  logic [2:0] vi_sel;
  logic [2:0] pwr_sel;
  logic [2:0] nxt;
  logic trig_edge;
  logic vi_done;
  logic [23:0] pwr_smp;
  logic [ACC_W-1:0] acc_new;
  logic [11:0] avg;
  logic [12:0] filt;

  assign chan_en = {cfg_q[CFG_TEMP_EN_BIT], cfg_q[CFG_VOUT_EN_BIT],
                    cfg_q[CFG_IN_VOLT_EN_BIT], 1'b1};
  assign vi_sel = cfg_q[CFG_VOLT_CURRENT_AVERAGE_LSB +: 3];
  assign pwr_sel = cfg_q[CFG_POWER_AVERAGE_LSB +: 3];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    run_d = run_q;
    cfg_d = cfg_q;
    peak_d = peak_q;
    meas_d = meas_q;
    acc_d = acc_q;
    pacc_d = pacc_q;
    pin_d = pin_q;
    vin_smp_d = vin_smp_q;
    cnt_d = cnt_q;
    pcnt_d = pcnt_q;
    ch_d = ch_q;
    start_d = 1'b0;
    trig_prev_d = CONVERSION_TRIGGER_INPUT;
    ss_prev_d = SPI_SS_N;
    nxt = next_chan(ch_q, chan_en);
    vi_done = 1'b0;
    pwr_smp = {12'h000, ADC_DATA} * {12'h000, vin_smp_q};
    acc_new = acc_q[ch_q] + ACC_W'(ADC_DATA);
    avg = 12'h000;
    filt = 13'h0000;

    // Host writes; a zero write restarts peak tracking, other values are ignored
    if (WR_STB)
    begin
      case (CMD_CODE)
        CMD_PEAK_CURRENT_HOLD, CMD_PEAK_INPUT_VOLTAGE_HOLD, CMD_PEAK_OUTPUT_VOLTAGE_HOLD:
          if (WR_DATA == PEAK_CLEAR_VALUE)
            peak_d[CMD_CODE[1:0]] = 12'h000;
        CMD_MONITOR_RUN_CONTROL:
          run_d = WR_DATA[RUN_BIT];
        CMD_MONITOR_SAMPLING_CONFIG:
          cfg_d = WR_DATA & CFG_WRITE_MASK;
        default:
          ;
      endcase
    end

    // Sampling sequencer
    case (state_q)
      S_IDLE:
      begin
        if (run_q)
        begin
          ch_d = CH_IOUT;
          cnt_d = 8'h00;
          pcnt_d = 8'h00;
          pacc_d = '0;
          for (int i = 0; i < 4; i++)
            acc_d[i] = '0;
          state_d = S_LAUNCH;
        end
      end
      S_LAUNCH:
      begin
        start_d = 1'b1;
        state_d = S_WAIT;
      end
      S_WAIT:
      begin
        if (ADC_DONE)
        begin
          acc_d[ch_q] = acc_new;
          if (ch_q == CH_VIN)
            vin_smp_d = ADC_DATA;
          // One power sample per rotation, from current and the latest input voltage
          if (ch_q == CH_IOUT)
          begin
            if (pcnt_q == last_count(pwr_sel))
            begin
              pin_d = 16'((PACC_W'(pacc_q) + PACC_W'(pwr_smp)) >> pwr_sel >> 8);
              pacc_d = '0;
              pcnt_d = 8'h00;
            end
            else
            begin
              pacc_d = pacc_q + PACC_W'(pwr_smp);
              pcnt_d = pcnt_q + 8'h01;
            end
          end
          ch_d = nxt[1:0];
          if (nxt[2])
          begin
            if (cnt_q == last_count(vi_sel))
              vi_done = 1'b1;
            else
              cnt_d = cnt_q + 8'h01;
          end
          state_d = S_LAUNCH;
        end
      end
      default:
        state_d = S_IDLE;
    endcase

    // Averaging window closed: publish enabled channels and update peaks
    if (vi_done)
    begin
      cnt_d = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
        acc_d[i] = '0;
        avg = 12'((((i == int'(ch_q)) ? acc_new : acc_q[i])) >> vi_sel);
        if (i == int'(CH_TEMP) && cfg_q[CFG_TEMP_FILTER_BIT])
        begin
          filt = ({1'b0, meas_q[i]} + {1'b0, avg}) >> 1;
          avg = filt[11:0];
        end
        if (chan_en[i])
          meas_d[i] = avg;
      end
      // Temperature has no peak register in this block, so only three channels track
      for (int i = 0; i < 3; i++)
      begin
        if (chan_en[i] && meas_d[i] > peak_d[i])
          peak_d[i] = meas_d[i];
      end
      if (!cfg_q[CFG_MODE_BIT])
        run_d = 1'b0;
    end

    // Trigger edges start a run only when the monitor is idle; set wins over a write
    trig_edge = (CONVERSION_TRIGGER_INPUT && !trig_prev_q) || (!SPI_SS_N && ss_prev_q);
    if (trig_edge && state_q == S_IDLE && !run_q)
      run_d = 1'b1;

    if (!run_d)
      state_d = S_IDLE;
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_valid_d = RD_STB;
    rd_data_d = rd_data_q;
    if (RD_STB)
    begin
      case (CMD_CODE)
        CMD_READ_IOUT: rd_data_d = {4'h0, meas_q[CH_IOUT]};
        CMD_READ_VIN: rd_data_d = {4'h0, meas_q[CH_VIN]};
        CMD_READ_VOUT: rd_data_d = {4'h0, meas_q[CH_VOUT]};
        CMD_READ_TEMP: rd_data_d = {4'h0, meas_q[CH_TEMP]};
        CMD_READ_PIN: rd_data_d = pin_q;
        CMD_PEAK_CURRENT_HOLD, CMD_PEAK_INPUT_VOLTAGE_HOLD, CMD_PEAK_OUTPUT_VOLTAGE_HOLD:
          rd_data_d = {4'h0, peak_q[CMD_CODE[1:0]]};
        CMD_MONITOR_RUN_CONTROL: rd_data_d = {15'h0000, run_q};
        CMD_MONITOR_SAMPLING_CONFIG: rd_data_d = cfg_q;
        default: rd_data_d = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_q <= S_IDLE;
      run_q <= RUN_RESET;
      cfg_q <= CFG_RESET;
      for (int i = 0; i < 3; i++)
        peak_q[i] <= 12'h000;
      for (int i = 0; i < 4; i++)
      begin
        meas_q[i] <= 12'h000;
        acc_q[i] <= '0;
      end
      pacc_q <= '0;
      pin_q <= 16'h0000;
      vin_smp_q <= 12'h000;
      cnt_q <= 8'h00;
      pcnt_q <= 8'h00;
      ch_q <= CH_IOUT;
      trig_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      run_q <= run_d;
      cfg_q <= cfg_d;
      peak_q <= peak_d;
      meas_q <= meas_d;
      acc_q <= acc_d;
      pacc_q <= pacc_d;
      pin_q <= pin_d;
      vin_smp_q <= vin_smp_d;
      cnt_q <= cnt_d;
      pcnt_q <= pcnt_d;
      ch_q <= ch_d;
      trig_prev_q <= trig_prev_d;
      ss_prev_q <= ss_prev_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      start_q <= start_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign ADC_START = start_q;
  assign ADC_CHAN = ch_q;
  assign ADC_SIMULTANEOUS = cfg_q[CFG_SIMUL_BIT];
  assign TEMP_FILTER_ENABLE = cfg_q[CFG_TEMP_FILTER_BIT];
  assign SAMPLING = run_q;

endmodule : pmon_sampling_ctrl

`default_nettype wire

// file: pmon_sampling_chk.sv
// Purpose: Port checker for the sampling control block
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pmon_sampling_chk
  import pmon_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] CMD_CODE,
  input wire logic WR_STB,
  input wire logic [15:0] WR_DATA,
  input wire logic RD_STB,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic CONVERSION_TRIGGER_INPUT,
  input wire logic SPI_SS_N,
  input wire logic ADC_START,
  input wire logic [1:0] ADC_CHAN,
  input wire logic ADC_DONE,
  input wire logic ADC_SIMULTANEOUS,
  input wire logic TEMP_FILTER_ENABLE,
  input wire logic SAMPLING
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  AST_RD_ANSWER: assert property (RD_STB |=> RD_VALID)
    else $error("read not answered");
  AST_RD_CAUSE: assert property (RD_VALID |-> $past(RD_STB))
    else $error("read answer without request");
  AST_RD_HOLD: assert property (!RD_STB |=> $stable(RD_DATA))
    else $error("read data moved without a read");
  AST_CTRL_READ: assert property (RD_STB && CMD_CODE == CMD_MONITOR_RUN_CONTROL |=>
    RD_DATA == {15'h0000, $past(SAMPLING)}) else $error("control readback wrong");
  AST_PEAK_TOP: assert property (RD_STB && CMD_CODE inside {8'hD0, 8'hD1, 8'hD2} |=>
    RD_DATA[15:12] == 4'h0) else $error("peak upper bits set");
  AST_CFG_RSVD: assert property (RD_STB && CMD_CODE == CMD_MONITOR_SAMPLING_CONFIG |=>
    (RD_DATA & ~CFG_WRITE_MASK) == 16'h0000) else $error("config reserved bits set");
  AST_START_PULSE: assert property (ADC_START |=> !ADC_START)
    else $error("conversion start longer than a cycle");
  AST_NEXT_START: assert property (ADC_DONE && SAMPLING ##1 SAMPLING ##1 SAMPLING |->
    ADC_START) else $error("next conversion not started two cycles after done");
  AST_CHAN_FIRST: assert property ($rose(SAMPLING) |-> ##2 ADC_CHAN == CH_IOUT)
    else $error("rotation did not begin with current");
  AST_STOP_QUIET: assert property ($fell(SAMPLING) |=> !ADC_START [*8])
    else $error("conversion started after stop");
  AST_TRIG_SET: assert property (!SAMPLING && $rose(CONVERSION_TRIGGER_INPUT) |=>
    SAMPLING) else $error("trigger rise did not start sampling");
  AST_SS_SET: assert property (!SAMPLING && $fell(SPI_SS_N) |=> SAMPLING)
    else $error("select fall did not start sampling");
  AST_SIMUL: assert property (WR_STB && CMD_CODE == CMD_MONITOR_SAMPLING_CONFIG |->
    ##2 ADC_SIMULTANEOUS == $past(WR_DATA[14], 2)) else $error("simultaneous out wrong");
  AST_TFILT: assert property (WR_STB && CMD_CODE == CMD_MONITOR_SAMPLING_CONFIG |->
    ##2 TEMP_FILTER_ENABLE == $past(WR_DATA[15], 2)) else $error("filter out wrong");
endmodule : pmon_sampling_chk
bind pmon_sampling_ctrl pmon_sampling_chk i_pmon_sampling_chk (.*);
`default_nettype wire

// file: pmon_adc_model.sv
// Purpose: Converter model answering start pulses
// Assumes: Result is level plus channel number
// Notes: Data toggles when not valid so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pmon_adc_model
(
  input wire logic mclk,
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  input wire logic slow,
  input wire logic [11:0] level,
  output logic adc_done,
  output logic [11:0] adc_data
);
  int cnt;
  logic [1:0] ch;
  initial
  begin
    adc_done = 1'b0;
    adc_data = 12'h000;
    cnt = 0;
    ch = 2'h0;
  end
  always @(posedge mclk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start)
    begin
      cnt <= slow ? 12 : 1;
      ch <= adc_chan;
    end
    else if (cnt == 1)
    begin
      adc_done <= 1'b1;
      adc_data <= level + {10'h000, ch};
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : pmon_adc_model
`default_nettype wire

// file: pmon_sampling_ctrl_tb.sv
// Purpose: Self-checking bench for the sampling control block
// Assumes: Inputs driven on the falling clock edge
// Notes: Peak expectations use level plus channel from the model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module pmon_sampling_ctrl_tb;
  logic mclk, rst_n, wr_stb, rd_stb, trig, ss_n, adc_start, adc_done, sim, tfe, sampling;
  logic rd_valid, slow;
  logic [7:0] cmd;
  logic [15:0] wdata, rdata;
  logic [1:0] chan;
  logic [11:0] adata, level;
  int mismatches, num_checks;
  pmon_sampling_ctrl i_pmon_sampling_ctrl (.MCLK(mclk), .RST_N(rst_n), .CMD_CODE(cmd),
    .WR_STB(wr_stb), .WR_DATA(wdata), .RD_STB(rd_stb), .RD_DATA(rdata), .RD_VALID(rd_valid),
    .CONVERSION_TRIGGER_INPUT(trig), .SPI_SS_N(ss_n), .ADC_START(adc_start), .ADC_CHAN(chan),
    .ADC_DONE(adc_done), .ADC_DATA(adata), .ADC_SIMULTANEOUS(sim),
    .TEMP_FILTER_ENABLE(tfe), .SAMPLING(sampling));
  pmon_adc_model i_pmon_adc_model (.mclk(mclk), .adc_start(adc_start), .adc_chan(chan),
    .slow(slow), .level(level), .adc_done(adc_done), .adc_data(adata));
  always #2 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge mclk);
    cmd = c;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge mclk);
    wr_stb = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    @(negedge mclk);
    cmd = c;
    rd_stb = 1'b1;
    @(negedge mclk);
    rd_stb = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rdata, e)
  endtask : rdc
  task automatic wait_off();
    for (int i = 0; i < 2000 && sampling !== 1'b0; i++)
      @(negedge mclk);
    `CHK(sampling, 1'b0)
  endtask : wait_off
  task automatic t_reset();
    rdc(8'hD0, 16'h0000);
    rdc(8'hD3, 16'h0001);
    rdc(8'hD4, 16'h0714);
    `CHK({sim, tfe}, 2'b00)
  endtask : t_reset
  task automatic t_stop();
    int n;
    n = 0;
    wr(8'hD3, 16'h0000);
    repeat (40)
    begin
      @(negedge mclk);
      if (adc_start === 1'b1)
        n++;
    end
    `CHK(n, 0)
    `CHK(sampling, 1'b0)
  endtask : t_stop
  task automatic t_config();
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hD4, {2'b00, i[2:0], i[2:0], 8'hFF});
      rdc(8'hD4, {2'b00, i[2:0], i[2:0], 8'h1E});
    end
    wr(8'hD4, 16'hFFFF);
    rdc(8'hD4, 16'hFF1E);
    `CHK({sim, tfe}, 2'b11)
    rdc(8'h00, 16'h0000);
    wr(8'hD4, 16'h001E);
    wr(8'hD3, 16'hFFFF);
    rdc(8'hD3, 16'h0001);
  endtask : t_config
  task automatic t_peaks();
    cyc(80);
    rdc(8'hD0, 16'h0100);
    rdc(8'hD1, 16'h0101);
    rdc(8'hD2, 16'h0102);
    rdc(8'h88, 16'h0101);
    rdc(8'h8C, 16'h0100);
    rdc(8'h8D, 16'h0103);
    rdc(8'h97, 16'h0101);
    level = 12'h080;
    cyc(80);
    rdc(8'hD0, 16'h0100);
    rdc(8'h8B, 16'h0082);
    level = 12'h200;
    cyc(80);
    rdc(8'hD1, 16'h0201);
    wr(8'hD0, 16'h0005);
    rdc(8'hD0, 16'h0200);
    level = 12'h040;
    // Let a window that holds old-level samples drain, or it would refill the peak
    cyc(24);
    wr(8'hD0, 16'h0000);
    cyc(80);
    rdc(8'hD0, 16'h0040);
    rdc(8'hD2, 16'h0202);
  endtask : t_peaks
  task automatic t_rotation();
    wr(8'hD4, 16'h0A14);
    level = 12'h300;
    cyc(120);
    rdc(8'h8B, 16'h0042);
    rdc(8'h88, 16'h0301);
    rdc(8'h8C, 16'h0300);
    rdc(8'hD1, 16'h0301);
    rdc(8'h97, 16'h0903);
    rdc(8'hD3, 16'h0001);
  endtask : t_rotation
  task automatic t_single();
    wr(8'hD3, 16'h0000);
    wr(8'hD4, 16'h000E);
    slow = 1'b1;
    cyc(5);
    trig = 1'b1;
    cyc(2);
    `CHK(sampling, 1'b1)
    trig = 1'b0;
    cyc(3);
    trig = 1'b1;
    ss_n = 1'b0;
    wait_off();
    cyc(30);
    `CHK(sampling, 1'b0)
    ss_n = 1'b1;
    cyc(3);
    ss_n = 1'b0;
    cyc(2);
    `CHK(sampling, 1'b1)
    wait_off();
  endtask : t_single
  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial
  begin
    #40000;
    mismatches++;
    close_out();
  end
  initial
  begin
    {mclk, rst_n, wr_stb, rd_stb, trig, slow} = 6'h00;
    ss_n = 1'b1;
    cmd = 8'h00;
    wdata = 16'h0000;
    level = 12'h100;
    mismatches = 0;
    num_checks = 0;
    cyc(3);
    rst_n = 1'b1;
    t_reset();
    t_stop();
    t_config();
    t_peaks();
    t_rotation();
    t_single();
    close_out();
  end
endmodule : pmon_sampling_ctrl_tb
`default_nettype wire
